/* pkg/kwdt_pkg.sv */
// Constants shared by the keyed watchdog timer.
// Assumes a 16-bit register port with 12-bit offsets into the config region.
package kwdt_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [11:0] OFF_CTL = 12'hcb0;
	localparam logic [11:0] OFF_CNT_LO = 12'hcb2;
	localparam logic [11:0] OFF_CNT_HI = 12'hcb4;
	localparam logic [11:0] OFF_ROUTE = 12'hd42;
	localparam logic [11:0] OFF_CAUSE = 12'hd74;

	// ------------------------------------------------------------
	// Key words
	// ------------------------------------------------------------
	localparam logic [15:0] KEY_OPEN1 = 16'h3333;
	localparam logic [15:0] KEY_OPEN2 = 16'hcccc;
	localparam logic [15:0] KEY_CLR1 = 16'haaaa;
	localparam logic [15:0] KEY_CLR2 = 16'h5555;

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int CTL_RUN_BIT = 15;
	localparam int CTL_RST_BIT = 14;
	localparam int CTL_IRQ_BIT = 12;
	localparam int EXP_W = 8;
	localparam int CNT_W = 31;
	localparam int CNT_LO_W = 16;
	localparam int CAUSE_WDT_BIT = 0;
	localparam int STRAP_W = 8;
	localparam logic [7:0] EXP_RST = 8'h80;
	localparam logic RST_ON_TO_RST = 1'b1;

	// Exponent of the lowest select bit, and the offset for higher bits
	localparam int EXP_FIRST = 14;
	localparam int EXP_BASE = 23;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int SYS_CLK_MHZ = 250;
	localparam int WDT_CLK_MHZ = 33;

	typedef enum logic [2:0] {KS_IDLE, KS_OPEN1, KS_OPEN, KS_CLR1} kwdt_key_e;

endpackage

/* logic/kwdt_top.sv */
// Keyed watchdog timer: counter, key sequencer, control and status registers.
// Assumes a synchronous single-cycle register port and an outside reset
// controller that turns sys_reset_o into a pulse on rst_n_i.
//
// Notes on behaviour
// - Enabling the watchdog clears the count, which then counts by itself.
// - Count advances by one per 33-MHz tick while enabled.
// - Time-out yields interrupt or system reset per reset_on_timeout.
// - Interrupt mode: first time-out interrupts and restarts; next one resets.
// - Open key 3333h then CCCCh permits exactly one data write.
// - Key words written with no open key pending are never stored into the control register.
// - Once running, control writes need a fresh open key.
// - Clear key AAAAh then 5555h zeroes the count at once.
// - AAAAh while open key pending is the data write.
// - Traffic to other addresses between key words does not break sequences; a control read does.
// - Time-out with interrupt flag still set forces a system reset.
// - Time-out comes after two to the selected exponent ticks.
// - Exponent field is writable only while run_enable is zero.
// - One-hot exponent: 00h none, 01h is 14, 02h..80h are 24..30.
// - Lowest set exponent bit wins, so F0h gives 27.
// - Debug mode halts the count; it resumes afterwards.
// - Watchdog reset does not resample the power-on straps.
// - Count readable as low half 15-0 and high half 30-16.
// - Reset status records a watchdog-caused system reset.
// - Interrupt flag cleared only by unlocked write of one.
// - While enabled only run_enable and interrupt flag are writable.
// - Power-on: disabled, maximum exponent, reset_on_timeout set.
module kwdt_top #(
	parameter int TICK_NUM = kwdt_pkg::WDT_CLK_MHZ,
	parameter int TICK_DEN = kwdt_pkg::SYS_CLK_MHZ,
	parameter int ROUTE_W = 16
) (
	// Clock and resets
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic power_good_in_i,
	// Register port
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [11:0] addr_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o,
	output logic rd_valid_o,
	// System
	input wire logic dbg_mode_i,
	input wire logic [kwdt_pkg::STRAP_W-1:0] strap_i,
	output logic [kwdt_pkg::STRAP_W-1:0] strap_o,
	output logic [ROUTE_W-1:0] irq_route_o,
	output logic irq_o,
	output logic sys_reset_o
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Terminal count is the limit minus one; zero select gives no time-out
	function automatic logic [kwdt_pkg::CNT_W-1:0] kwdt_term(input logic [kwdt_pkg::EXP_W-1:0] sel);
		logic [kwdt_pkg::CNT_W-1:0] t;
		t = '0;
		for (int i = kwdt_pkg::EXP_W - 1; i >= 0; i--)
		begin
			if (sel[i])
				t = (31'h1 << (i == 0 ? kwdt_pkg::EXP_FIRST : kwdt_pkg::EXP_BASE + i)) - 31'h1;
		end
		return t;
	endfunction

	localparam int ACC_W = $clog2(TICK_DEN + TICK_NUM);
	localparam logic [ACC_W-1:0] ACC_NUM = ACC_W'(TICK_NUM);
	localparam logic [ACC_W-1:0] ACC_DEN = ACC_W'(TICK_DEN);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	kwdt_pkg::kwdt_key_e key_r, key_nxt;
	logic run_en_r, rst_on_to_r, irq_flag_r;
	logic [kwdt_pkg::EXP_W-1:0] exp_r;
	logic [kwdt_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic [ACC_W-1:0] acc_r;
	logic cause_wdt_r;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire logic wr_ctl_w = wr_i && (addr_i == kwdt_pkg::OFF_CTL);
	wire logic rd_ctl_w = rd_i && (addr_i == kwdt_pkg::OFF_CTL);
	wire logic wr_cause_w = wr_i && (addr_i == kwdt_pkg::OFF_CAUSE);
	wire logic wr_route_w = wr_i && (addr_i == kwdt_pkg::OFF_ROUTE);
	wire logic [ACC_W-1:0] acc_sum_w = acc_r + ACC_NUM;
	wire logic tick_w = acc_sum_w >= ACC_DEN;
	wire logic [kwdt_pkg::CNT_W-1:0] term_w = kwdt_term(exp_r);
	wire logic data_wr_w = wr_ctl_w && (key_r == kwdt_pkg::KS_OPEN);
	wire logic clr_key_w = wr_ctl_w && (key_r == kwdt_pkg::KS_CLR1) && (wdata_i == kwdt_pkg::KEY_CLR2);
	wire logic en_rise_w = data_wr_w && !run_en_r && wdata_i[kwdt_pkg::CTL_RUN_BIT];
	wire logic counting_w = run_en_r && tick_w && !dbg_mode_i;
	wire logic hit_w = counting_w && (exp_r != '0) && (cnt_r == term_w);
	wire logic to_reset_w = hit_w && (rst_on_to_r || irq_flag_r);
	wire logic to_irq_w = hit_w && !rst_on_to_r && !irq_flag_r;

	// ------------------------------------------------------------
	// Key sequencer
	// ------------------------------------------------------------
	// Only control-address accesses move it, so other traffic may interleave
	always_comb
	begin
		key_nxt = key_r;
		if (wr_ctl_w)
		begin
			unique case (key_r)
				kwdt_pkg::KS_OPEN: key_nxt = kwdt_pkg::KS_IDLE;
				kwdt_pkg::KS_IDLE, kwdt_pkg::KS_OPEN1, kwdt_pkg::KS_CLR1:
				begin
					if (wdata_i == kwdt_pkg::KEY_OPEN1)
						key_nxt = kwdt_pkg::KS_OPEN1;
					else if (wdata_i == kwdt_pkg::KEY_CLR1)
						key_nxt = kwdt_pkg::KS_CLR1;
					else if (key_r == kwdt_pkg::KS_OPEN1 && wdata_i == kwdt_pkg::KEY_OPEN2)
						key_nxt = kwdt_pkg::KS_OPEN;
					else
						key_nxt = kwdt_pkg::KS_IDLE;
				end
				default: key_nxt = kwdt_pkg::KS_IDLE;
			endcase
		end
		else if (rd_ctl_w)
			key_nxt = kwdt_pkg::KS_IDLE;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			key_r <= kwdt_pkg::KS_IDLE;
		else
			key_r <= key_nxt;
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			run_en_r <= 1'b0;
			rst_on_to_r <= kwdt_pkg::RST_ON_TO_RST;
			exp_r <= kwdt_pkg::EXP_RST;
			irq_flag_r <= 1'b0;
		end
		else
		begin
			if (data_wr_w)
				run_en_r <= wdata_i[kwdt_pkg::CTL_RUN_BIT];
			if (data_wr_w && !run_en_r)
			begin
				rst_on_to_r <= wdata_i[kwdt_pkg::CTL_RST_BIT];
				exp_r <= wdata_i[kwdt_pkg::EXP_W-1:0];
			end
			// Hardware set beats a same-cycle software clear
			if (to_irq_w)
				irq_flag_r <= 1'b1;
			else if (data_wr_w && wdata_i[kwdt_pkg::CTL_IRQ_BIT])
				irq_flag_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Counter and tick divider
	// ------------------------------------------------------------
	// Fractional divider: 33 ticks every 250 cycles, jitter of one cycle
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (en_rise_w || clr_key_w || hit_w)
			cnt_nxt = '0;
		else if (counting_w)
			cnt_nxt = cnt_r + 31'h1;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			cnt_r <= '0;
			acc_r <= '0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			acc_r <= tick_w ? acc_sum_w - ACC_DEN : acc_sum_w;
		end
	end

	// ------------------------------------------------------------
	// Outputs, routing and reset cause
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			irq_o <= 1'b0;
			sys_reset_o <= 1'b0;
			irq_route_o <= '0;
		end
		else
		begin
			irq_o <= to_irq_w;
			sys_reset_o <= to_reset_w;
			if (wr_route_w)
				irq_route_o <= wdata_i[ROUTE_W-1:0];
		end
	end

	// Power-good domain: survives the watchdog's own system reset
	always_ff @(posedge clk_sys_i)
	begin
		if (!power_good_in_i)
		begin
			cause_wdt_r <= 1'b0;
			strap_o <= strap_i;
		end
		else if (to_reset_w)
			cause_wdt_r <= 1'b1;
		else if (wr_cause_w && wdata_i[kwdt_pkg::CAUSE_WDT_BIT])
			cause_wdt_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [15:0] rd_mux_w;
	always_comb
	begin
		rd_mux_w = 16'h0000;
		unique case (addr_i)
			kwdt_pkg::OFF_CTL:
			begin
				rd_mux_w[kwdt_pkg::CTL_RUN_BIT] = run_en_r;
				rd_mux_w[kwdt_pkg::CTL_RST_BIT] = rst_on_to_r;
				rd_mux_w[kwdt_pkg::CTL_IRQ_BIT] = irq_flag_r;
				rd_mux_w[kwdt_pkg::EXP_W-1:0] = exp_r;
			end
			kwdt_pkg::OFF_CNT_LO: rd_mux_w = cnt_r[kwdt_pkg::CNT_LO_W-1:0];
			kwdt_pkg::OFF_CNT_HI: rd_mux_w = {1'b0, cnt_r[kwdt_pkg::CNT_W-1:kwdt_pkg::CNT_LO_W]};
			kwdt_pkg::OFF_ROUTE: rd_mux_w[ROUTE_W-1:0] = irq_route_o;
			kwdt_pkg::OFF_CAUSE: rd_mux_w[kwdt_pkg::CAUSE_WDT_BIT] = cause_wdt_r;
			default: rd_mux_w = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			rdata_o <= 16'h0000;
			rd_valid_o <= 1'b0;
		end
		else
		begin
			rd_valid_o <= rd_i;
			if (rd_i)
				rdata_o <= rd_mux_w;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Internal decode is watched directly; bus timing is left to the bench
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_open_key;
		wr_ctl_w && wdata_i == kwdt_pkg::KEY_OPEN2 && key_r == kwdt_pkg::KS_OPEN1;
	endsequence

	sequence s_key_word;
		wr_ctl_w && key_r != kwdt_pkg::KS_OPEN;
	endsequence

	sequence s_data_write;
		data_wr_w;
	endsequence

	sequence s_timeout;
		hit_w;
	endsequence

	chk_enable_clears: assert property (en_rise_w |=> run_en_r && cnt_r == '0)
		else $error("Enable did not clear count");
	chk_count_step: assert property (counting_w && !hit_w && !clr_key_w && !en_rise_w
		|=> cnt_r == $past(cnt_r) + 31'h1)
		else $error("Count did not step by one");
	chk_debug_hold: assert property (dbg_mode_i && !clr_key_w && !en_rise_w |=> $stable(cnt_r))
		else $error("Count moved in debug mode");
	chk_first_timeout: assert property (to_irq_w |=> irq_o && irq_flag_r && !sys_reset_o && cnt_r == '0)
		else $error("First time-out mishandled");
	chk_second_reset: assert property (hit_w && irq_flag_r |=> sys_reset_o && !irq_o)
		else $error("Second time-out did not reset");
	chk_open_arms: assert property (s_open_key |=> key_r == kwdt_pkg::KS_OPEN)
		else $error("Open key did not arm the register");
	chk_open_single: assert property (s_data_write |=> key_r == kwdt_pkg::KS_IDLE)
		else $error("Open key allowed more than one write");
	chk_key_not_stored: assert property (s_key_word |=> $stable(exp_r) && $stable(run_en_r)
		&& $stable(rst_on_to_r))
		else $error("Key word altered control");
	chk_locked_fields: assert property (run_en_r |=> $stable(exp_r) && $stable(rst_on_to_r))
		else $error("Field changed while running");
	chk_clear_key: assert property (clr_key_w |=> cnt_r == '0)
		else $error("Clear key did not zero count");
	// Limit minus one is all ones below the exponent and zero above it
	chk_timeout_point: assert property (s_timeout |-> cnt_r[kwdt_pkg::EXP_FIRST-1:0] == '1
		&& ((cnt_r + 31'h1) & cnt_r) == '0)
		else $error("Time-out at wrong count");
	chk_single_event: assert property (s_timeout |=> !hit_w)
		else $error("Time-out detected twice");
	chk_strap_hold: assert property (@(posedge clk_sys_i) disable iff (!power_good_in_i)
		1'b1 |=> $stable(strap_o))
		else $error("Straps resampled");
	chk_cause_set: assert property (@(posedge clk_sys_i) disable iff (!power_good_in_i)
		to_reset_w |=> cause_wdt_r)
		else $error("Reset cause not recorded");
	chk_cause_clear: assert property (@(posedge clk_sys_i) disable iff (!power_good_in_i)
		wr_cause_w && wdata_i[kwdt_pkg::CAUSE_WDT_BIT] && !to_reset_w |=> !cause_wdt_r)
		else $error("Reset cause not cleared");

	chk_lowest_exp: assert property (hit_w && exp_r[0]
		|-> cnt_r == (31'h1 << kwdt_pkg::EXP_FIRST) - 31'h1)
		else $error("Lowest exponent bit ignored");
	// Flag is cleared only by an unlocked write of one
	chk_flag_clear: assert property (data_wr_w && wdata_i[kwdt_pkg::CTL_IRQ_BIT] && !to_irq_w
		|=> !irq_flag_r)
		else $error("Interrupt flag not cleared");
	chk_flag_hold: assert property (irq_flag_r && !data_wr_w |=> irq_flag_r)
		else $error("Interrupt flag lost without a write");
	chk_halt_disabled: assert property (!run_en_r && !en_rise_w && !clr_key_w |=> $stable(cnt_r))
		else $error("Count moved while disabled");
	chk_irq_once: assert property (irq_o |=> !irq_o)
		else $error("Interrupt pulse too long");
	chk_reset_once: assert property (sys_reset_o |=> !sys_reset_o)
		else $error("Reset pulse too long");
	chk_unkeyed_write: assert property (wr_ctl_w && key_r == kwdt_pkg::KS_IDLE
		&& wdata_i != kwdt_pkg::KEY_OPEN1 && wdata_i != kwdt_pkg::KEY_CLR1
		|=> key_r == kwdt_pkg::KS_IDLE && $stable(exp_r) && $stable(run_en_r))
		else $error("Unkeyed write was taken");

endmodule

/* bench/kwdt_top_tb.sv */
// Self-checking bench for the keyed watchdog timer.
// Assumes the divider is set to tick every cycle; the bench acts as reset controller.
module kwdt_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [11:0] CTL = kwdt_pkg::OFF_CTL;
	localparam logic [11:0] LO = kwdt_pkg::OFF_CNT_LO;
	localparam logic [11:0] CAUSE = kwdt_pkg::OFF_CAUSE;
	logic clk_sys_i, rst_n_i, power_good_in_i, wr_i, rd_i, dbg_mode_i, rd_valid_o, irq_o, sys_reset_o;
	logic [11:0] addr_i;
	logic [15:0] wdata_i, rdata_o, irq_route_o, va, vb;
	logic [kwdt_pkg::STRAP_W-1:0] strap_i, strap_o;
	logic [1:0] ev;
	int err_total, n_tests, cyc, t0, t1;
	kwdt_top #(.TICK_NUM(1), .TICK_DEN(1)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.power_good_in_i(power_good_in_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.rdata_o(rdata_o), .rd_valid_o(rd_valid_o), .dbg_mode_i(dbg_mode_i), .strap_i(strap_i),
		.strap_o(strap_o), .irq_route_o(irq_route_o), .irq_o(irq_o), .sys_reset_o(sys_reset_o));
	initial
	begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) cyc <= cyc + 1;
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic stop_test();
		if (err_total == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [15:0] d);
		@(posedge clk_sys_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		chk("rd_valid", 16'h0001, {15'h0, rd_valid_o});
		d = rdata_o;
	endtask
	task automatic rc(input logic [11:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk($sformatf("reg_%h", a), e, d);
	endtask
	task automatic unlock();
		wr(CTL, kwdt_pkg::KEY_OPEN1);
		wr(CTL, kwdt_pkg::KEY_OPEN2);
	endtask
	// Bounded wait for a time-out pulse; the pulse must last one cycle
	task automatic wait_evt(output logic [1:0] e, output int t);
		int n;
		for (n = 0; n < 20000 && !(irq_o === 1'b1 || sys_reset_o === 1'b1); n++)
		begin
			@(posedge clk_sys_i);
			#1;
		end
		if (n >= 20000)
		begin
			err_total++;
			stop_test();
		end
		e = {irq_o, sys_reset_o};
		t = cyc;
		@(posedge clk_sys_i);
		#1;
		chk("pulse_end", 16'h0000, {14'h0, irq_o, sys_reset_o});
	endtask
	task automatic chk_len(input int dt);
		chk("timeout_len", 16'h0001, {15'h0, dt >= 16383 && dt <= 16386});
	endtask
	task automatic wdt_reset();
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_keys();
		rc(CTL, 16'h4080);
		rc(12'h000, 16'h0000);
		wr(CTL, 16'h0001);
		rc(CTL, 16'h4080);
		wr(CTL, kwdt_pkg::KEY_OPEN1);
		wr(kwdt_pkg::OFF_ROUTE, 16'h1234);
		wr(CTL, kwdt_pkg::KEY_OPEN2);
		rd(LO, va);
		wr(CTL, 16'h0002);
		rc(CTL, 16'h0002);
		chk("route", 16'h1234, irq_route_o);
		wr(CTL, 16'h0004);
		rc(CTL, 16'h0002);
		unlock();
		wr(CTL, kwdt_pkg::KEY_CLR1);
		rc(CTL, 16'h80aa);
		rd(LO, va);
		rd(LO, vb);
		chk("count_step", 16'h0002, vb - va);
		@(posedge clk_sys_i);
		dbg_mode_i <= 1'b1;
		rd(LO, va);
		rd(LO, vb);
		chk("count_halt", 16'h0000, vb - va);
		dbg_mode_i <= 1'b0;
		repeat (100) @(posedge clk_sys_i);
		wr(CTL, kwdt_pkg::KEY_CLR1);
		wr(CTL, kwdt_pkg::KEY_CLR2);
		rd(LO, va);
		chk("count_clear", 16'h0001, {15'h0, va < 16'h0004});
		rc(kwdt_pkg::OFF_CNT_HI, 16'h0000);
		unlock();
		wr(CTL, 16'h8001);
		rc(CTL, 16'h80aa);
		wr(CTL, 16'h0000);
		rc(CTL, 16'h80aa);
		unlock();
		wr(CTL, 16'h0000);
		rc(CTL, 16'h00aa);
	endtask
	task automatic t_reset_mode();
		strap_i <= 8'h3c;
		unlock();
		wr(CTL, 16'h4001);
		unlock();
		wr(CTL, 16'hc001);
		#1 t0 = cyc;
		wait_evt(ev, t1);
		chk("event", 16'h0001, {14'h0, ev});
		chk_len(t1 - t0);
		wdt_reset();
		rc(CAUSE, 16'h0001);
		chk("strap", 16'h00a5, {8'h0, strap_o});
		rc(CTL, 16'h4080);
		wr(CAUSE, 16'h0001);
		rc(CAUSE, 16'h0000);
	endtask
	task automatic t_irq_mode();
		unlock();
		wr(CTL, 16'h8003);
		#1 t0 = cyc;
		wait_evt(ev, t1);
		chk("event", 16'h0002, {14'h0, ev});
		chk_len(t1 - t0);
		rc(CTL, 16'h9003);
		rc(CTL, 16'h9003);
		wr(CTL, 16'h1000);
		rc(CTL, 16'h9003);
		unlock();
		wr(CTL, 16'h9003);
		rc(CTL, 16'h8003);
		wait_evt(ev, t0);
		chk("event", 16'h0002, {14'h0, ev});
		wait_evt(ev, t1);
		chk("event", 16'h0001, {14'h0, ev});
		chk_len(t1 - t0);
		wdt_reset();
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		{rst_n_i, power_good_in_i, wr_i, rd_i, dbg_mode_i} = 5'h0;
		addr_i = 12'h000;
		wdata_i = 16'h0000;
		strap_i = 8'ha5;
		{cyc, err_total, n_tests} = 0;
		repeat (20) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		power_good_in_i <= 1'b1;
		@(posedge clk_sys_i);
		t_keys();
		t_reset_mode();
		t_irq_mode();
		stop_test();
	end
endmodule
